// *** logic/main_config_reg.sv ***
// Purpose: main configuration register and the controls it drives
// Assumes: host writes arrive as a one-cycle strobe on clk
// Notes: calibrate and power-down pins are asynchronous and synchronised
`timescale 1ns/100ps
`include "main_config_cfg.svh"

// How it works
// - write one starts calibration; bit stays set
// - field ORed with pin; rise from zero
// - double rate: phase bit picks 0 or 90
// - single rate: phase bit picks clock edge
// - bit 13 picks output swing
// - bit 12 outputs fixed test pattern
// - bit 11 or pin powers down I
// - bit 10 or pin powers down Q
// - power-save forces low-rate, ignores field
// - bit 7 selects interleaved sampling
// - bit 6 picks Q input when interleaved
// - bit 5 shorts inputs when interleaved
// - bit 2 picks single or double rate
// - bit 4 picks two's complement format
// - outside extended mode, defaults, writes ignored
module main_config_reg
   import main_config_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic extended_control_mode,
   input wire logic low_rate_power_save,
   input wire logic write_strobe,
   input wire logic [3:0] write_addr,
   input wire logic [15:0] write_data,
   input wire logic calibrate_pin,
   input wire logic i_power_down_pin,
   input wire logic q_power_down_pin,
   output logic [15:0] main_configuration,
   output logic calibration_start,
   output logic output_clock_phase_sel,
   output logic single_rate_output,
   output logic phase_90_sel,
   output logic data_on_falling_edge,
   output logic high_swing_sel,
   output logic test_pattern_sel,
   output logic i_channel_power_down,
   output logic q_channel_power_down,
   output logic low_clock_rate_sel,
   output logic interleave_on_i_input,
   output logic interleave_q_input_sel,
   output logic interleave_shorted_inputs,
   output input_mode_type input_mode,
   output logic twos_complement_sel,
   output logic time_stamp_enable
);
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic [15:0] next_config;
   logic cal_request;
   logic cal_request_prev;
   // reset value of high_swing_sel is read from the register's reset word; the other decoded outputs reset to zero
   localparam logic [15:0] reset_word = `MAIN_CONFIGURATION_RESET;

   // two-stage synchronisers for the three pins
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
      end else begin
         pin_meta <= {calibrate_pin, i_power_down_pin, q_power_down_pin};
         pin_sync <= pin_meta;
      end
   end

   // reserved bits are masked so they always hold their default of zero
   always_comb begin
      next_config = main_configuration;
      if (!extended_control_mode) begin
         next_config = `MAIN_CONFIGURATION_RESET;
      end else if (write_strobe && write_addr == `MAIN_CONFIGURATION_ADDR) begin
         next_config = write_data & `WRITE_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         main_configuration <= `MAIN_CONFIGURATION_RESET;
      end else begin
         main_configuration <= next_config;
      end
   end

   // rising edge of the ORed request starts one calibration
   always_comb begin
      cal_request = main_configuration[`BIT_CALIBRATE] | pin_sync[2];
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cal_request_prev <= 1'b0;
         calibration_start <= 1'b0;
      end else begin
         cal_request_prev <= cal_request;
         calibration_start <= cal_request & ~cal_request_prev;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         output_clock_phase_sel <= 1'b0;
         single_rate_output <= 1'b0;
         phase_90_sel <= 1'b0;
         data_on_falling_edge <= 1'b0;
         high_swing_sel <= reset_word[`BIT_SWING];
         test_pattern_sel <= 1'b0;
         i_channel_power_down <= 1'b0;
         q_channel_power_down <= 1'b0;
         low_clock_rate_sel <= 1'b0;
         twos_complement_sel <= 1'b0;
         time_stamp_enable <= 1'b0;
      end else begin
         output_clock_phase_sel <= next_config[`BIT_PHASE];
         single_rate_output <= next_config[`BIT_SINGLE_RATE];
         phase_90_sel <= next_config[`BIT_PHASE] & ~next_config[`BIT_SINGLE_RATE];
         data_on_falling_edge <= next_config[`BIT_PHASE] & next_config[`BIT_SINGLE_RATE];
         high_swing_sel <= next_config[`BIT_SWING];
         test_pattern_sel <= next_config[`BIT_TEST_PATTERN];
         i_channel_power_down <= next_config[`BIT_I_POWER_DOWN] | pin_sync[1];
         q_channel_power_down <= next_config[`BIT_Q_POWER_DOWN] | pin_sync[0];
         // power-save applies the low-rate setting itself
         low_clock_rate_sel <= low_rate_power_save | next_config[`BIT_LOW_RATE];
         twos_complement_sel <= next_config[`BIT_TWOS];
         time_stamp_enable <= next_config[`BIT_TIME_STAMP];
      end
   end

   // without bit 7 the mode falls back to dual; with bits 6 and 5 both set, shorted wins
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         interleave_on_i_input <= 1'b0;
         interleave_q_input_sel <= 1'b0;
         interleave_shorted_inputs <= 1'b0;
         input_mode <= input_dual;
      end else begin
         interleave_on_i_input <= next_config[`BIT_INTERLEAVE];
         interleave_q_input_sel <= next_config[`BIT_INTERLEAVE] & next_config[`BIT_Q_INPUT];
         interleave_shorted_inputs <= next_config[`BIT_INTERLEAVE] & next_config[`BIT_SHORTED];
         if (!next_config[`BIT_INTERLEAVE]) begin
            input_mode <= input_dual;
         end else if (next_config[`BIT_SHORTED]) begin
            input_mode <= input_shorted;
         end else if (next_config[`BIT_Q_INPUT]) begin
            input_mode <= input_q;
         end else begin
            input_mode <= input_i;
         end
      end
   end

   sequence cal_rise_s;
      !cal_request ##1 cal_request;
   endsequence

   cal_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
      cal_rise_s |=> calibration_start)
      else $error("calibration start missing after rise");
   cal_single_a: assert property (@(posedge clk) disable iff (!reset_n)
      calibration_start |=> !calibration_start)
      else $error("calibration start longer than one cycle");
   cal_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      main_configuration[`BIT_CALIBRATE] && extended_control_mode
      && !write_strobe |=> main_configuration[`BIT_CALIBRATE])
      else $error("calibrate bit cleared by device");
   non_ecm_default_a: assert property (@(posedge clk) disable iff (!reset_n)
      !extended_control_mode |=> main_configuration == `MAIN_CONFIGURATION_RESET)
      else $error("register not default outside extended mode");
   i_power_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
      i_power_down_pin [*3] |=> i_channel_power_down)
      else $error("I power-down pin ignored");
   q_power_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
      q_power_down_pin [*3] |=> q_channel_power_down)
      else $error("Q power-down pin ignored");
   low_rate_save_a: assert property (@(posedge clk) disable iff (!reset_n)
      low_rate_power_save |=> low_clock_rate_sel)
      else $error("low rate not forced in power-save");
   phase_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 !(phase_90_sel && data_on_falling_edge))
      else $error("phase meanings overlap");
   write_take_a: assert property (@(posedge clk) disable iff (!reset_n)
      extended_control_mode && write_strobe && write_addr == `MAIN_CONFIGURATION_ADDR
      |=> interleave_on_i_input == $past(write_data[`BIT_INTERLEAVE]))
      else $error("interleave bit not taken from write");
   swing_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 high_swing_sel == main_configuration[`BIT_SWING])
      else $error("swing output does not follow register");

   // a write that the register takes
   sequence write_accept_s;
      extended_control_mode && write_strobe && write_addr == `MAIN_CONFIGURATION_ADDR;
   endsequence

   // pin rises while the field is clear: the only pin rise that may start a calibration
   sequence pin_rise_s;
      (!calibrate_pin && !main_configuration[`BIT_CALIBRATE]) [*3]
      ##1 (calibrate_pin && !main_configuration[`BIT_CALIBRATE]) [*3];
   endsequence

   cal_pin_start_a: assert property (@(posedge clk) disable iff (!reset_n)
      pin_rise_s |=> calibration_start)
      else $error("calibrate pin rise did not start calibration");
   pattern_take_a: assert property (@(posedge clk) disable iff (!reset_n)
      write_accept_s |=> test_pattern_sel == $past(write_data[`BIT_TEST_PATTERN]))
      else $error("test pattern bit not taken from write");
   format_take_a: assert property (@(posedge clk) disable iff (!reset_n)
      write_accept_s |=> twos_complement_sel == $past(write_data[`BIT_TWOS]))
      else $error("number format bit not taken from write");
   rate_take_a: assert property (@(posedge clk) disable iff (!reset_n)
      write_accept_s |=> single_rate_output == $past(write_data[`BIT_SINGLE_RATE]))
      else $error("output rate bit not taken from write");
   phase_ninety_a: assert property (@(posedge clk) disable iff (!reset_n)
      write_accept_s |=> phase_90_sel
      == ($past(write_data[`BIT_PHASE]) & !$past(write_data[`BIT_SINGLE_RATE])))
      else $error("double rate phase wrong after write");
   falling_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
      write_accept_s |=> data_on_falling_edge
      == ($past(write_data[`BIT_PHASE]) & $past(write_data[`BIT_SINGLE_RATE])))
      else $error("single rate edge wrong after write");
   q_input_take_a: assert property (@(posedge clk) disable iff (!reset_n)
      write_accept_s |=> interleave_q_input_sel
      == ($past(write_data[`BIT_INTERLEAVE]) & $past(write_data[`BIT_Q_INPUT])))
      else $error("Q input select wrong after write");
   shorted_take_a: assert property (@(posedge clk) disable iff (!reset_n)
      write_accept_s |=> interleave_shorted_inputs
      == ($past(write_data[`BIT_INTERLEAVE]) & $past(write_data[`BIT_SHORTED])))
      else $error("shorted inputs wrong after write");
endmodule

// *** pkg/main_config_cfg.svh ***
// Purpose: constants for the main configuration register
// Assumes: 16-bit register at address 0 of a 4-bit address space
// Notes: low-rate bit defaults to zero; power-save mode forces the low-rate output
`ifndef MAIN_CONFIG_CFG_SVH
`define MAIN_CONFIG_CFG_SVH
`define MAIN_CONFIGURATION_ADDR 4'h0
`define MAIN_CONFIGURATION_RESET 16'h2000
`define BIT_CALIBRATE 15
`define BIT_PHASE 14
`define BIT_SWING 13
`define BIT_TEST_PATTERN 12
`define BIT_I_POWER_DOWN 11
`define BIT_Q_POWER_DOWN 10
`define BIT_LOW_RATE 8
`define BIT_INTERLEAVE 7
`define BIT_Q_INPUT 6
`define BIT_SHORTED 5
`define BIT_TWOS 4
`define BIT_TIME_STAMP 3
`define BIT_SINGLE_RATE 2
`define WRITE_MASK 16'hfdfc
`endif

// *** pkg/main_config_pkg.sv ***
// Purpose: types for the main configuration register
// Assumes: nothing beyond the constants header
// Notes: input selection of the interleaved mode
package main_config_pkg;
   typedef enum logic [1:0] {
      input_dual = 2'b00,
      input_i = 2'b01,
      input_q = 2'b10,
      input_shorted = 2'b11
   } input_mode_type;
endpackage

// *** sim/host_writer.sv ***
// Purpose: host side that writes the configuration register
// Assumes: one-cycle write strobe, driven 1 ns after clk rises
// Notes: released lines carry inverted values so stale data is never trusted
`timescale 1ns/100ps
module host_writer (
   input wire logic clk,
   output logic write_strobe,
   output logic [3:0] write_addr,
   output logic [15:0] write_data
);
   initial begin
      write_strobe = 1'b0;
      write_addr = 4'hf;
      write_data = 16'h0000;
   end
   task automatic send(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      write_strobe = 1'b1;
      write_addr = a;
      write_data = d & 16'hfdfc;
      @(posedge clk);
      #1;
      write_strobe = 1'b0;
      write_addr = ~a;
      write_data = ~d;
   endtask
endmodule

// *** sim/test_adc_main_config_register.sv ***
// Purpose: self-checking bench for the main configuration register
// Assumes: one clock, synchronous active-low reset held 20 cycles
// Notes: a word model is compared with every output but calibration_start after each write
`timescale 1ns/100ps
module test_adc_main_config_register;
   import main_config_pkg::*;
   logic clk, reset_n, ext_mode, save_mode, cal_pin, pd_i, pd_q, strobe, cal_pulse;
   logic [3:0] addr;
   logic [15:0] wdata, cfg, d, e;
   logic [13:0] dec;
   input_mode_type mode;
   int bad_count = 0, checked = 0, cal_count = 0, m, n, r = 32'h7f1f;
   logic [2:0] modes[4] = '{3'b000, 3'b100, 3'b110, 3'b101};
   logic [15:0] cd[10] = '{0, 'h8000, 'h8000, 0, 'h8000, 'h8000, 0, 0, 0, 0};
   bit cp[10] = '{0, 0, 0, 0, 0, 1, 1, 0, 1, 0};
   int ce[10] = '{0, 1, 0, 0, 1, 0, 0, 0, 1, 0};
   host_writer host (.clk(clk), .write_strobe(strobe), .write_addr(addr), .write_data(wdata));
   main_config_reg dut (.clk(clk), .reset_n(reset_n), .extended_control_mode(ext_mode),
      .low_rate_power_save(save_mode), .write_strobe(strobe), .write_addr(addr),
      .write_data(wdata), .calibrate_pin(cal_pin), .i_power_down_pin(pd_i),
      .q_power_down_pin(pd_q), .main_configuration(cfg), .calibration_start(cal_pulse),
      .output_clock_phase_sel(dec[13]), .single_rate_output(dec[12]),
      .phase_90_sel(dec[11]), .data_on_falling_edge(dec[10]), .high_swing_sel(dec[9]),
      .test_pattern_sel(dec[8]), .i_channel_power_down(dec[7]),
      .q_channel_power_down(dec[6]), .low_clock_rate_sel(dec[5]),
      .interleave_on_i_input(dec[4]), .interleave_q_input_sel(dec[3]),
      .interleave_shorted_inputs(dec[2]), .input_mode(mode),
      .twos_complement_sel(dec[1]), .time_stamp_enable(dec[0]));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (cal_pulse === 1'b1) cal_count++;
   function automatic int lfsr(int x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [15:0] expect_dec(int v);
      logic [1:0] im;
      im = !v[7] ? 2'b00 : v[5] ? 2'b11 : v[6] ? 2'b10 : 2'b01;
      return {v[14], v[2], v[14] & !v[2], v[14] & v[2], v[13], v[12], v[11] | pd_i,
         v[10] | pd_q, v[8] | save_mode, v[7], v[7] & v[6], v[7] & v[5], v[4], v[3], im};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // settle 4 edges so pin synchronisers and the register have landed
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      host.send(a, v);
      if (ext_mode && a == 4'h0) m = v & 16'hfdfc;
      if (!ext_mode) m = 'h2000;
      repeat (4) @(posedge clk);
      #1;
      e = expect_dec(m);
      chk(cfg, m[15:0]);
      chk(dec[13:6], e[15:8]);
      chk({dec[5:0], mode}, e[7:0]);
   endtask
   initial begin
      {reset_n, ext_mode, save_mode, cal_pin, pd_i, pd_q} = 6'b010000;
      m = 'h2000;
      repeat (20) @(posedge clk);
      #1 reset_n = 1'b1;
      @(posedge clk);
      #1;
      e = expect_dec(m);
      chk(cfg, 16'h2000);
      chk({dec, mode}, e);
      $display("test reset done");
      repeat (300) begin
         r = lfsr(r);
         {ext_mode, save_mode, pd_i, pd_q} = {r[31:29] != 3'h0, r[28:26]};
         d = r[15:0];
         d[7:5] = modes[r[17:16]];
         wr(r[20] ? r[27:24] : 4'h0, d);
      end
      $display("test random writes done");
      {ext_mode, save_mode, pd_i, pd_q} = 4'b1000;
      foreach (cd[i]) begin
         n = cal_count;
         cal_pin = cp[i];
         wr(4'h0, cd[i]);
         chk(16'(cal_count - n), 16'(ce[i]));
      end
      $display("test calibration done");
      results();
   end
   initial begin
      #160000;
      bad_count++;
      results();
   end
endmodule
